//--- design/onoff_control_heater_alarm.sv
// Purpose: ON/OFF regulation with heater burnout and short alarms
// Assumes: Process value and CT currents synchronous, tenths of a unit
// Notes: PID regulation lives elsewhere; heatOut and coolOut stay off in PID mode
`default_nettype none
module onoff_control_heater_alarm
    import onoff_pkg::*;
#(
    parameter int SAMPLE_CNT = onoff_pkg::SAMPLE_CYCLES,
    parameter int SKIP_CNT = onoff_pkg::SKIP_CYCLES,
    parameter int SKIP_FAST_CNT = onoff_pkg::SKIP_FAST_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] processValue,
    input wire logic [15:0] heaterCurrent,
    input wire logic [15:0] leakageCurrent,
    output logic heatOut,
    output logic coolOut,
    output logic burnoutAlarm,
    output logic shortAlarm,
    output logic irq
);
    import onoff_pkg::*;

    localparam int SAMPLE_W = $clog2(SAMPLE_CNT + 1);
    localparam int OFF_W = $clog2(SKIP_CNT + 2);
    localparam logic [SAMPLE_W-1:0] SAMPLE_LAST =
        SAMPLE_W'(SAMPLE_CNT - 1);
    localparam logic [OFF_W-1:0] OFF_MAX = OFF_W'(SKIP_CNT + 1);
    localparam logic [OFF_W-1:0] SKIP_LIM = OFF_W'(SKIP_CNT);
    localparam logic [OFF_W-1:0] SKIP_FAST_LIM = OFF_W'(SKIP_FAST_CNT);

    method_t controlMethodSelect_reg;
    logic actionDirectionSelect_reg;
    logic heatCool_reg;
    logic fastPeriod_reg;
    logic signed [15:0] setPoint_reg;
    logic [15:0] heatingHysteresis_reg;
    logic [15:0] coolingHysteresis_reg;
    logic [15:0] heatCoolDeadBand_reg;
    logic [15:0] burnoutThresholdOne_reg;
    logic [15:0] shortThresholdOne_reg;
    logic [15:0] heaterCurrentMonitor_reg;
    logic [15:0] leakageCurrentMonitorOne_reg;
    logic [INT_W-1:0] intStat_reg;
    logic [INT_W-1:0] intStat_next;
    logic [INT_W-1:0] intMask_reg;
    logic [SAMPLE_W-1:0] sampleCnt_reg;
    logic tick_reg;
    logic [OFF_W-1:0] offCnt_reg;
    logic offLong;
    logic onOffMode;
    logic coolEnable;
    logic coolDirect;
    logic setupPhase;
    logic writeTaken;
    logic thrWriteOk;
    logic burnRise;
    logic shortRise;
    logic burnoutAlarm_next;
    logic shortAlarm_next;

    assign setupPhase = psel && !penable;
    assign writeTaken = psel && penable && pready && pwrite;
    // Out-of-range threshold writes are ignored, old value kept
    assign thrWriteOk = pwdata[15:0] <= THR_FORCE_HIGH;
    assign onOffMode = controlMethodSelect_reg == METHOD_ONOFF;
    assign coolEnable = onOffMode && heatCool_reg;
    assign coolDirect = !actionDirectionSelect_reg;

    ////////////////////////////////////////////////////////////////////
    // APB slave: no wait state, answer prepared in the setup cycle

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && (paddr[1:0] != 2'b00 ||
                paddr > ADDR_INT_MASK);
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            case (paddr)
                ADDR_CTRL: prdata <= {28'h0000000, fastPeriod_reg,
                    heatCool_reg, actionDirectionSelect_reg,
                    onOffMode};
                ADDR_SETPOINT: prdata <= {16'h0000, setPoint_reg};
                ADDR_HEAT_HYST: prdata <= {16'h0000, heatingHysteresis_reg};
                ADDR_COOL_HYST: prdata <= {16'h0000, coolingHysteresis_reg};
                ADDR_DEAD_BAND: prdata <= {16'h0000, heatCoolDeadBand_reg};
                ADDR_BURN_THR: prdata <= {16'h0000, burnoutThresholdOne_reg};
                ADDR_SHORT_THR: prdata <= {16'h0000, shortThresholdOne_reg};
                ADDR_STATUS: prdata <= {28'h0000000, shortAlarm,
                    burnoutAlarm, coolOut, heatOut};
                ADDR_HEATER_MON:
                    prdata <= {16'h0000, heaterCurrentMonitor_reg};
                ADDR_LEAK_MON:
                    prdata <= {16'h0000, leakageCurrentMonitorOne_reg};
                ADDR_INT_STAT: prdata <= {30'h00000000, intStat_reg};
                ADDR_INT_MASK: prdata <= {30'h00000000, intMask_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            controlMethodSelect_reg <= METHOD_PID;
            actionDirectionSelect_reg <= CTRL_RESET[CTRL_DIRECT_BIT];
            heatCool_reg <= CTRL_RESET[CTRL_HEATCOOL_BIT];
            fastPeriod_reg <= CTRL_RESET[CTRL_FASTPERIOD_BIT];
            setPoint_reg <= SETPOINT_RESET;
            heatingHysteresis_reg <= HEAT_HYST_RESET;
            coolingHysteresis_reg <= COOL_HYST_RESET;
            heatCoolDeadBand_reg <= DEAD_BAND_RESET;
            intMask_reg <= '0;
        end else if (writeTaken) begin
            case (paddr)
                ADDR_CTRL: begin
                    controlMethodSelect_reg <= pwdata[CTRL_METHOD_BIT] ?
                        METHOD_ONOFF : METHOD_PID;
                    actionDirectionSelect_reg <= pwdata[CTRL_DIRECT_BIT];
                    heatCool_reg <= pwdata[CTRL_HEATCOOL_BIT];
                    fastPeriod_reg <= pwdata[CTRL_FASTPERIOD_BIT];
                end
                ADDR_SETPOINT: setPoint_reg <= pwdata[15:0];
                ADDR_HEAT_HYST: heatingHysteresis_reg <= pwdata[15:0];
                ADDR_COOL_HYST: coolingHysteresis_reg <= pwdata[15:0];
                ADDR_DEAD_BAND: heatCoolDeadBand_reg <= pwdata[15:0];
                ADDR_INT_MASK: intMask_reg <= pwdata[INT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            burnoutThresholdOne_reg <= BURN_THR_RESET;
            shortThresholdOne_reg <= SHORT_THR_RESET;
        end else if (writeTaken && thrWriteOk) begin
            if (paddr == ADDR_BURN_THR) begin
                burnoutThresholdOne_reg <= pwdata[15:0];
            end
            if (paddr == ADDR_SHORT_THR) begin
                shortThresholdOne_reg <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sampling period and heating off-time

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sampleCnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (sampleCnt_reg == SAMPLE_LAST) begin
            sampleCnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            sampleCnt_reg <= sampleCnt_reg + SAMPLE_W'(1);
            tick_reg <= 1'b0;
        end
    end

    // Saturates just past the longer limit, so no wrap back to short
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            offCnt_reg <= '0;
        end else if (heatOut) begin
            offCnt_reg <= '0;
        end else if (offCnt_reg != OFF_MAX) begin
            offCnt_reg <= offCnt_reg + OFF_W'(1);
        end
    end

    assign offLong = offCnt_reg >
        (fastPeriod_reg ? SKIP_FAST_LIM : SKIP_LIM);

    ////////////////////////////////////////////////////////////////////
    // Output channels

    onoff_channel #(.W(16)) heatChannel (
        .clock(clock),
        .reset_n(reset_n),
        .enable(onOffMode),
        .tick(tick_reg),
        .direct(actionDirectionSelect_reg),
        .pv(processValue),
        .sp(setPoint_reg),
        .offset(16'h0000),
        .hyst(heatingHysteresis_reg),
        .outOn(heatOut)
    );

    onoff_channel #(.W(16)) coolChannel (
        .clock(clock),
        .reset_n(reset_n),
        .enable(coolEnable),
        .tick(tick_reg),
        .direct(coolDirect),
        .pv(processValue),
        .sp(setPoint_reg),
        .offset(heatCoolDeadBand_reg),
        .hyst(coolingHysteresis_reg),
        .outOn(coolOut)
    );

    ////////////////////////////////////////////////////////////////////
    // Heater alarms and current monitors

    always_comb begin
        burnoutAlarm_next = burnoutAlarm;
        if (burnoutThresholdOne_reg == THR_FORCE_LOW) begin
            burnoutAlarm_next = 1'b0;
        end else if (burnoutThresholdOne_reg == THR_FORCE_HIGH) begin
            burnoutAlarm_next = 1'b1;
        end else if (heatOut) begin
            burnoutAlarm_next =
                heaterCurrent < burnoutThresholdOne_reg;
        end
    end

    // Only the heating output gates the short check
    always_comb begin
        shortAlarm_next = shortAlarm;
        if (shortThresholdOne_reg == THR_FORCE_LOW) begin
            shortAlarm_next = 1'b1;
        end else if (shortThresholdOne_reg == THR_FORCE_HIGH) begin
            shortAlarm_next = 1'b0;
        end else if (!heatOut && offLong) begin
            shortAlarm_next =
                leakageCurrent > shortThresholdOne_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            burnoutAlarm <= 1'b0;
            shortAlarm <= 1'b0;
        end else if (tick_reg) begin
            burnoutAlarm <= burnoutAlarm_next;
            shortAlarm <= shortAlarm_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            heaterCurrentMonitor_reg <= '0;
            leakageCurrentMonitorOne_reg <= '0;
        end else if (tick_reg) begin
            heaterCurrentMonitor_reg <= heaterCurrent > CURRENT_LIMIT ?
                MONITOR_OVERFLOW : heaterCurrent;
            leakageCurrentMonitorOne_reg <=
                leakageCurrent > CURRENT_LIMIT ?
                MONITOR_OVERFLOW : leakageCurrent;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts: sticky on alarm rise, write one to clear

    assign burnRise = tick_reg && burnoutAlarm_next && !burnoutAlarm;
    assign shortRise = tick_reg && shortAlarm_next && !shortAlarm;

    // A rise in the clearing cycle survives the clear
    always_comb begin
        intStat_next = intStat_reg;
        if (writeTaken && paddr == ADDR_INT_STAT) begin
            intStat_next = intStat_reg & ~pwdata[INT_W-1:0];
        end
        if (burnRise) begin
            intStat_next[INT_BURN_BIT] = 1'b1;
        end
        if (shortRise) begin
            intStat_next[INT_SHORT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            intStat_reg <= '0;
            irq <= 1'b0;
        end else begin
            intStat_reg <= intStat_next;
            irq <= |(intStat_reg & intMask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_burn_low_thr: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && burnoutThresholdOne_reg == THR_FORCE_LOW
        |=> !burnoutAlarm)
        else $error("burnout alarm not held off at zero threshold");
    a_short_low_thr: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && shortThresholdOne_reg == THR_FORCE_LOW |=> shortAlarm)
        else $error("short alarm not held on at zero threshold");
    a_full_thr: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && burnoutThresholdOne_reg == THR_FORCE_HIGH &&
        shortThresholdOne_reg == THR_FORCE_HIGH
        |=> burnoutAlarm && !shortAlarm)
        else $error("full threshold alarms wrong");
    a_thr_range: assert property (@(posedge clock)
        disable iff (!reset_n)
        writeTaken && paddr == ADDR_BURN_THR && pwdata[15:0] > THR_FORCE_HIGH
        |=> $stable(burnoutThresholdOne_reg))
        else $error("out of range threshold accepted");
    a_mon_overflow: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && leakageCurrent > CURRENT_LIMIT
        |=> leakageCurrentMonitorOne_reg == MONITOR_OVERFLOW)
        else $error("leakage monitor missed overflow code");
    a_short_skip: assert property (@(posedge clock)
        disable iff (!reset_n)
        !offLong && shortThresholdOne_reg != THR_FORCE_LOW &&
        shortThresholdOne_reg != THR_FORCE_HIGH |=> $stable(shortAlarm))
        else $error("short alarm moved inside skip interval");
    a_short_detect: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && !heatOut && offLong &&
        shortThresholdOne_reg != THR_FORCE_LOW &&
        shortThresholdOne_reg != THR_FORCE_HIGH &&
        leakageCurrent > shortThresholdOne_reg |=> shortAlarm)
        else $error("short alarm missed leakage above threshold");
    a_short_clear: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && !heatOut && offLong &&
        shortThresholdOne_reg != THR_FORCE_LOW &&
        shortThresholdOne_reg != THR_FORCE_HIGH &&
        leakageCurrent <= shortThresholdOne_reg |=> !shortAlarm)
        else $error("short alarm kept with leakage below threshold");
    a_burn_detect: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && heatOut && burnoutThresholdOne_reg != THR_FORCE_LOW &&
        burnoutThresholdOne_reg != THR_FORCE_HIGH &&
        heaterCurrent < burnoutThresholdOne_reg |=> burnoutAlarm)
        else $error("burnout alarm missed low heater current");
    a_burn_clear: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg && heatOut && burnoutThresholdOne_reg != THR_FORCE_LOW &&
        burnoutThresholdOne_reg != THR_FORCE_HIGH &&
        heaterCurrent >= burnoutThresholdOne_reg |=> !burnoutAlarm)
        else $error("burnout alarm kept with normal heater current");
    a_pid_quiet: assert property (@(posedge clock)
        disable iff (!reset_n)
        !onOffMode |=> !heatOut && !coolOut)
        else $error("output driven while PID selected");
    a_tick_spacing: assert property (@(posedge clock)
        disable iff (!reset_n)
        tick_reg |=> !tick_reg)
        else $error("sampling tick on consecutive cycles");
    a_hyst_reset: assert property (@(posedge clock)
        !reset_n |=> heatingHysteresis_reg == HEAT_HYST_RESET)
        else $error("heating hysteresis reset value wrong");

    c_heat_on: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(heatOut));
    c_short_alarm: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(shortAlarm));
    c_burn_alarm: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(burnoutAlarm));
    c_irq: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(irq));
endmodule
`default_nettype wire

//--- design/onoff_pkg.sv
// Purpose: Shared constants of the ON/OFF regulator and heater alarms
// Assumes: 40 MHz clock; temperatures and currents in tenths of a unit
// Notes: Register offsets are byte addresses on a 32-bit APB slave
`default_nettype none
package onoff_pkg;
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SETPOINT = 8'h04;
    localparam logic [7:0] ADDR_HEAT_HYST = 8'h08;
    localparam logic [7:0] ADDR_COOL_HYST = 8'h0C;
    localparam logic [7:0] ADDR_DEAD_BAND = 8'h10;
    localparam logic [7:0] ADDR_BURN_THR = 8'h14;
    localparam logic [7:0] ADDR_SHORT_THR = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_HEATER_MON = 8'h20;
    localparam logic [7:0] ADDR_LEAK_MON = 8'h24;
    localparam logic [7:0] ADDR_INT_STAT = 8'h28;
    localparam logic [7:0] ADDR_INT_MASK = 8'h2C;
    // CTRL fields
    localparam int CTRL_METHOD_BIT = 0;
    localparam int CTRL_DIRECT_BIT = 1;
    localparam int CTRL_HEATCOOL_BIT = 2;
    localparam int CTRL_FASTPERIOD_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // STATUS fields
    localparam int STAT_HEAT_BIT = 0;
    localparam int STAT_COOL_BIT = 1;
    localparam int STAT_BURN_BIT = 2;
    localparam int STAT_SHORT_BIT = 3;
    // Interrupt fields
    localparam int INT_BURN_BIT = 0;
    localparam int INT_SHORT_BIT = 1;
    localparam int INT_W = 2;
    // Reset values, tenths of a unit
    localparam logic [15:0] HEAT_HYST_RESET = 16'h000A;
    localparam logic [15:0] COOL_HYST_RESET = 16'h000A;
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam logic [15:0] DEAD_BAND_RESET = 16'h0000;
    localparam logic [15:0] BURN_THR_RESET = 16'h0000;
    localparam logic [15:0] SHORT_THR_RESET = 16'h01F4;
    // Threshold codes, tenths of an ampere
    localparam logic [15:0] THR_FORCE_LOW = 16'h0000;
    localparam logic [15:0] THR_FORCE_HIGH = 16'h01F4;
    localparam logic [15:0] CURRENT_LIMIT = 16'h0226;
    localparam logic [15:0] MONITOR_OVERFLOW = 16'hFFFF;
    // Timing
    localparam int CLOCK_KHZ = 40_000;
    localparam int SAMPLE_PERIOD_MS = 1;
    localparam int SHORT_SKIP_MS = 100;
    localparam int SHORT_SKIP_FAST_MS = 35;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * CLOCK_KHZ;
    localparam int SKIP_CYCLES = SHORT_SKIP_MS * CLOCK_KHZ;
    localparam int SKIP_FAST_CYCLES = SHORT_SKIP_FAST_MS * CLOCK_KHZ;
    typedef enum logic {METHOD_PID, METHOD_ONOFF} method_t;
endpackage
`default_nettype wire

//--- design/onoff_channel.sv
// Purpose: One ON/OFF output with hysteresis around a set point
// Assumes: Evaluation only on the sampling tick
// Notes: Reverse sense heats, direct sense cools
`default_nettype none
module onoff_channel #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic tick,
    input wire logic direct,
    input wire logic signed [W-1:0] pv,
    input wire logic signed [W-1:0] sp,
    input wire logic [W-1:0] offset,
    input wire logic [W-1:0] hyst,
    output logic outOn
);
    logic signed [W+1:0] p;
    logic signed [W+1:0] s;
    logic signed [W+1:0] h;

    // Dead band moves the switching point away from the set point
    assign p = (W+2)'(pv);
    assign s = direct ? (W+2)'(sp) + (W+2)'(offset)
                      : (W+2)'(sp) - (W+2)'(offset);
    assign h = (W+2)'(hyst);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            outOn <= 1'b0;
        end else if (!enable) begin
            outOn <= 1'b0;
        end else if (tick) begin
            if (direct) begin
                if (p <= s) begin
                    outOn <= 1'b0;
                end else if (p > s + h) begin
                    outOn <= 1'b1;
                end
            end else begin
                if (p >= s) begin
                    outOn <= 1'b0;
                end else if (p < s - h) begin
                    outOn <= 1'b1;
                end
            end
        end
    end

    a_off_at_sp: assert property (@(posedge clock) disable iff (!reset_n)
        enable && tick && !direct && p >= s |=> !outOn)
        else $error("output still on at set point");
    a_on_below_band: assert property (@(posedge clock)
        disable iff (!reset_n)
        enable && tick && !direct && !outOn && p >= s - h |=> !outOn)
        else $error("output turned on inside hysteresis band");
    a_direct_sense: assert property (@(posedge clock)
        disable iff (!reset_n)
        enable && tick && direct && p > s + h |=> outOn)
        else $error("direct sense did not switch on above band");
endmodule
`default_nettype wire

//--- verification/heater_load.sv
// Purpose: Heater load and current transformer at the far side
// Assumes: Heater current flows only while heating is driven, leakage current only while it is off
// Notes: Burnout and leakage faults are commanded by the bench
`default_nettype none
module heater_load (
    input wire logic heatOn,
    input wire logic burnt,
    input wire logic leaky,
    input wire logic [15:0] rated,
    output logic [15:0] heaterCurrent,
    output logic [15:0] leakageCurrent
);
    // A burnt element draws nothing
    assign heaterCurrent = (heatOn && !burnt) ? rated : 16'h0000;
    // A shorted switch leaks full current while off
    assign leakageCurrent = (!heatOn && leaky) ? rated : 16'h0000;
endmodule
`default_nettype wire

//--- verification/onoff_control_heater_alarm_bench.sv
// Purpose: Self-checking bench of the regulator and heater alarms
// Assumes: Short sample and skip counts for a fast run
// Notes: Expected heating output in the process-value sweep comes from a behavioural hysteresis model
`default_nettype none
module onoff_control_heater_alarm_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import onoff_pkg::*;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic signed [15:0] pv = 16'h0000;
    logic burnt = 0, leaky = 0, prev = 0, err;
    logic [15:0] rated = 16'h0032, hc, lc;
    logic pready, pslverr, heatOut, coolOut, burnoutAlarm, shortAlarm, irq;
    int fail_count = 0, total_checks = 0, p;
    int unsigned seed = 85;
    int tab[5] = '{200, 191, 189, 199, 200};
    onoff_control_heater_alarm #(.SAMPLE_CNT(8), .SKIP_CNT(20),
        .SKIP_FAST_CNT(7)) dut (.clock(clock), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .processValue(pv), .heaterCurrent(hc),
        .leakageCurrent(lc), .heatOut(heatOut), .coolOut(coolOut),
        .burnoutAlarm(burnoutAlarm), .shortAlarm(shortAlarm), .irq(irq));
    heater_load load (.heatOn(heatOut), .burnt(burnt), .leaky(leaky),
        .rated(rated), .heaterCurrent(hc), .leakageCurrent(lc));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clock = ~clock;
    end
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Off at or above the set point; equality at the lower bound holds the old state
    function automatic logic mdl(int v, int s, int h, logic q);
        return (v >= s) ? 1'b0 : (v < s - h) ? 1'b1 : q;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Entered just after a rising edge; holds until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Three sampling periods let two decisions land
    task automatic step(input int v);
        pv <= 16'(v);
        repeat (24) @(posedge clock);
    endtask
    // Only the watchdog ends a hang here
    task automatic wait_off();
        do @(posedge clock);
        while (heatOut !== 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, ADDR_HEAT_HYST, 32'h0);
        chk(rd, 32'h0000000A);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk(err, 1'b1);
        wr(ADDR_BURN_THR, 32'h01F5);
        apb(1'b0, ADDR_BURN_THR, 32'h0);
        chk(rd, 32'h0);
        wr(ADDR_BURN_THR, 32'h01F3);
        apb(1'b0, ADDR_BURN_THR, 32'h0);
        chk(rd, 32'h01F3);
        wr(ADDR_BURN_THR, 32'h0);
        wr(ADDR_SHORT_THR, 32'h0);
        step(0);
        chk(heatOut, 1'b0);
        chk(burnoutAlarm, 1'b0);
        chk(shortAlarm, 1'b1);
        wr(ADDR_BURN_THR, 32'h01F4);
        wr(ADDR_SHORT_THR, 32'h01F4);
        step(0);
        chk(burnoutAlarm, 1'b1);
        chk(shortAlarm, 1'b0);
        wr(ADDR_INT_MASK, 32'h1);
        step(0);
        chk(irq, 1'b1);
        wr(ADDR_INT_STAT, 32'h1);
        step(0);
        chk(irq, 1'b0);
        wr(ADDR_BURN_THR, 32'h001E);
        wr(ADDR_SHORT_THR, 32'h001E);
        wr(ADDR_SETPOINT, 32'h00C8);
        wr(ADDR_CTRL, 32'h1);
        for (int i = 0; i < 10; i++) begin
            p = (i < 5) ? tab[i] : 180 + int'(rnd() % 40);
            step(p);
            prev = mdl(p, 200, 10, prev);
            chk(heatOut, prev);
        end
        step(150);
        chk(burnoutAlarm, 1'b0);
        burnt <= 1'b1;
        step(150);
        chk(burnoutAlarm, 1'b1);
        burnt <= 1'b0;
        leaky <= 1'b1;
        pv <= 16'sh00FA;
        wait_off();
        repeat (10) @(posedge clock);
        chk(shortAlarm, 1'b0);
        repeat (30) @(posedge clock);
        chk(shortAlarm, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000008);
        apb(1'b0, ADDR_LEAK_MON, 32'h0);
        chk(rd, 32'h00000032);
        leaky <= 1'b0;
        rated <= 16'h0227;
        step(150);
        apb(1'b0, ADDR_HEATER_MON, 32'h0);
        chk(rd, 32'h0000FFFF);
        rated <= 16'h0226;
        step(150);
        apb(1'b0, ADDR_HEATER_MON, 32'h0);
        chk(rd, 32'h00000226);
        wr(ADDR_CTRL, 32'h3);
        step(215);
        chk(heatOut, 1'b1);
        step(200);
        chk(heatOut, 1'b0);
        wr(ADDR_COOL_HYST, 32'h003C);
        wr(ADDR_CTRL, 32'h5);
        step(200);
        step(250);
        chk(coolOut, 1'b0);
        step(265);
        chk(coolOut, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        step(265);
        chk(coolOut, 1'b0);
        // Fast period: short check opens after the shorter off time
        wr(ADDR_CTRL, 32'h9);
        step(150);
        leaky <= 1'b1;
        pv <= 16'sh00FA;
        wait_off();
        repeat (20) @(posedge clock);
        chk(shortAlarm, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
